/* mctr_regs.vh */
// Constants for the multi-channel temperature result logic
// Summary of operation
// - Results have 13 bits, 0.0625 C steps
// - Two-byte words, negatives in two's complement
// - Left-justified; one step reads 00 08
// - Word spans -256 to 255.9375 C
// - High byte coarse 2 C, low byte remainder 0 to 1.9375 C
// - Shorted remote input reports -256 C
// - Fault comparator watched; sets remote open bit
// - One hysteresis value serves both alerts
// - Two active-low alerts follow limit comparisons
// - Each conversion done within 17 ms
// - One local and eight remote channels
// - Four target addresses chosen by select pin
// - Zero ideality setting assumes factor 1.008
// - Results at pointers 00h-08h, mirrored 80h-88h
`ifndef MCTR_REGS_VH
`define MCTR_REGS_VH
`define MCTR_NUM_CH          9
`define MCTR_CH_W            4
`define MCTR_RAW_W           13
`define MCTR_WORD_W          16
`define MCTR_PAD_BITS        3'h0
`define MCTR_SHORT_VALUE     16'h8000
`define MCTR_RESET_RESULT    16'h0000
`define MCTR_PTR_BASE        8'h00
`define MCTR_PTR_LAST        8'h08
`define MCTR_PTR_MIRROR      8'h80
`define MCTR_PTR_MIRROR_LAST 8'h88
`define MCTR_ADDR_BASE       7'h48
`define MCTR_CLK_MHZ         250
`define MCTR_CONV_MAX_MS     17
`define MCTR_IDEALITY_ZERO   16'h0000
`define MCTR_IDEALITY_X1000  1008
`endif

/* mctr_alert.v */
// Alert comparator with hysteresis for one alert output
`timescale 1ns/10ps
`default_nettype none
`include "mctr_regs.vh"
module mctr_alert
(
    input  wire                           clk_in,
    input  wire                           rst_n_in,
    input  wire                           upd_in,
    input  wire [`MCTR_WORD_W-1:0]        temp_in,
    input  wire [`MCTR_WORD_W-1:0]        limit_in,
    input  wire [`MCTR_WORD_W-1:0]        hyst_in,
    output reg                            active_out
);
    // Two guard bits keep limit minus hysteresis from wrapping
    wire signed [`MCTR_WORD_W+1:0] release_lvl;
    wire signed [`MCTR_WORD_W+1:0] temp_s;
    wire signed [`MCTR_WORD_W+1:0] limit_s;
    assign temp_s      = {{2{temp_in[`MCTR_WORD_W-1]}}, temp_in};
    assign limit_s     = {{2{limit_in[`MCTR_WORD_W-1]}}, limit_in};
    assign release_lvl = limit_s - {2'h0, hyst_in};
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            active_out <= 1'b0;
        else if (upd_in)
        begin
            if (temp_s > limit_s)
                active_out <= 1'b1;
            else if (temp_s < release_lvl)
                active_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* mctr_top.v */
// Result formatting, fault flags and alert outputs of the nine-channel monitor
`timescale 1ns/10ps
`default_nettype none
`include "mctr_regs.vh"
module mctr_top
(
    input  wire                           mclk_in,
    input  wire                           rst_n_in,
    input  wire                           conv_done_in,
    input  wire [`MCTR_CH_W-1:0]          conv_ch_in,
    input  wire [`MCTR_RAW_W-1:0]         conv_raw_in,
    input  wire                           short_in,
    input  wire                           fault_cmp_in,
    input  wire                           conv_active_in,
    input  wire [1:0]                     addr_sel_in,
    input  wire [7:0]                     ptr_in,
    input  wire [15:0]                    ideality_in,
    input  wire [`MCTR_WORD_W-1:0]        hyst_in,
    input  wire [`MCTR_NUM_CH*`MCTR_WORD_W-1:0] limit1_in,
    input  wire [`MCTR_NUM_CH*`MCTR_WORD_W-1:0] limit2_in,
    output reg  [`MCTR_WORD_W-1:0]        rd_word_out,
    output reg                            rd_valid_out,
    output reg  [`MCTR_NUM_CH-2:0]        remote_open_fault_bit_out,
    output reg  [6:0]                     target_addr_out,
    output reg                            ideality_default_out,
    output reg                            conv_timeout_out,
    output reg                            primary_overtemp_alert_n_out,
    output reg                            secondary_overtemp_alert_n_out
);
    // ************************************
    // Timing
    // ************************************
    localparam integer CONV_MAX_CYC = `MCTR_CONV_MAX_MS * 1000 * `MCTR_CLK_MHZ;
    parameter integer CONV_LIMIT = CONV_MAX_CYC;

    // ************************************
    // Input synchronisers
    // ************************************
    reg [1:0] fault_s_q;
    reg [1:0] short_s_q;
    reg [1:0] asel0_q;
    reg [1:0] asel1_q;
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fault_s_q <= 2'h0;
            short_s_q <= 2'h0;
            asel0_q   <= 2'h0;
            asel1_q   <= 2'h0;
        end
        else
        begin
            fault_s_q <= {fault_s_q[0], fault_cmp_in};
            short_s_q <= {short_s_q[0], short_in};
            asel0_q   <= {asel0_q[0], addr_sel_in[0]};
            asel1_q   <= {asel1_q[0], addr_sel_in[1]};
        end
    end

    // ************************************
    // Result storage
    // ************************************
    function [`MCTR_CH_W-1:0] ptr_to_ch;
        input [7:0] p;
        begin
            ptr_to_ch = p[`MCTR_CH_W-1:0];
        end
    endfunction
    function ptr_ok;
        input [7:0] p;
        begin
            ptr_ok = (p <= `MCTR_PTR_LAST) ||
                     (p >= `MCTR_PTR_MIRROR && p <= `MCTR_PTR_MIRROR_LAST);
        end
    endfunction

    reg  [`MCTR_WORD_W-1:0] result_q [0:`MCTR_NUM_CH-1];
    wire [`MCTR_WORD_W-1:0] fmt_word;
    wire                    is_remote;
    wire                    ch_ok;
    reg                     upd_q;
    assign is_remote = (conv_ch_in != 4'h0);
    assign ch_ok     = (conv_ch_in < `MCTR_NUM_CH);
    // Left-justified two's complement, high byte 2 C per LSB
    assign fmt_word  = (is_remote && short_s_q[1]) ? `MCTR_SHORT_VALUE
                     : {conv_raw_in, `MCTR_PAD_BITS};

    genvar gi;
    generate
        for (gi = 0; gi < `MCTR_NUM_CH; gi = gi + 1)
        begin : g_res
            always @(posedge mclk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    result_q[gi] <= `MCTR_RESET_RESULT;
                else if (conv_done_in && conv_ch_in == gi)
                    result_q[gi] <= fmt_word;
            end
        end
    endgenerate

    // ************************************
    // Remote fault flags and update strobe
    // ************************************
    wire [2:0] fault_idx;
    wire       fault_hit;
    // Channel n maps to fault bit n-1; channel 8 wraps to bit 7
    assign fault_idx = conv_ch_in[2:0] - 3'h1;
    assign fault_hit = conv_active_in && is_remote && ch_ok && fault_s_q[1];

    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            upd_q <= 1'b0;
        else
            upd_q <= conv_done_in && ch_ok;
    end

    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            remote_open_fault_bit_out <= 8'h00;
        else if (fault_hit)
            remote_open_fault_bit_out[fault_idx] <= 1'b1;
    end

    // ************************************
    // Conversion watchdog
    // ************************************
    reg [31:0] conv_cnt_q;
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            conv_cnt_q       <= 32'h0000_0000;
            conv_timeout_out <= 1'b0;
        end
        else
        begin
            if (!conv_active_in || conv_done_in)
                conv_cnt_q <= 32'h0000_0000;
            else
                conv_cnt_q <= conv_cnt_q + 32'h0000_0001;
            conv_timeout_out <= conv_active_in && (conv_cnt_q >= CONV_LIMIT);
        end
    end

    // ************************************
    // Read port
    // ************************************
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rd_word_out  <= `MCTR_RESET_RESULT;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            rd_valid_out <= ptr_ok(ptr_in);
            rd_word_out  <= ptr_ok(ptr_in) ? result_q[ptr_to_ch(ptr_in)] : `MCTR_RESET_RESULT;
        end
    end

    // ************************************
    // Address and ideality
    // ************************************
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            target_addr_out      <= `MCTR_ADDR_BASE;
            ideality_default_out <= 1'b0;
        end
        else
        begin
            target_addr_out      <= `MCTR_ADDR_BASE | {5'h00, asel1_q[1], asel0_q[1]};
            ideality_default_out <= (ideality_in == `MCTR_IDEALITY_ZERO);
        end
    end

    // ************************************
    // Overtemperature alerts
    // ************************************
    wire [`MCTR_NUM_CH-1:0] al1;
    wire [`MCTR_NUM_CH-1:0] al2;
    generate
        for (gi = 0; gi < `MCTR_NUM_CH; gi = gi + 1)
        begin : g_al
            mctr_alert u_a1
            (
                .clk_in     (mclk_in),
                .rst_n_in   (rst_n_in),
                .upd_in     (upd_q),
                .temp_in    (result_q[gi]),
                .limit_in   (limit1_in[gi*`MCTR_WORD_W +: `MCTR_WORD_W]),
                .hyst_in    (hyst_in),
                .active_out (al1[gi])
            );
            mctr_alert u_a2
            (
                .clk_in     (mclk_in),
                .rst_n_in   (rst_n_in),
                .upd_in     (upd_q),
                .temp_in    (result_q[gi]),
                .limit_in   (limit2_in[gi*`MCTR_WORD_W +: `MCTR_WORD_W]),
                .hyst_in    (hyst_in),
                .active_out (al2[gi])
            );
        end
    endgenerate

    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            primary_overtemp_alert_n_out   <= 1'b1;
            secondary_overtemp_alert_n_out <= 1'b1;
        end
        else
        begin
            primary_overtemp_alert_n_out   <= ~(|al1);
            secondary_overtemp_alert_n_out <= ~(|al2);
        end
    end
endmodule
`default_nettype wire

/* mctr_properties.sv */
// Checker for the result logic top
`timescale 1ns/10ps
`default_nettype none
module mctr_properties #(parameter integer CONV_LIMIT = 100)
(
    input wire         mclk_in,
    input wire         rst_n_in,
    input wire         conv_done_in,
    input wire [3:0]   conv_ch_in,
    input wire [12:0]  conv_raw_in,
    input wire         fault_cmp_in,
    input wire         conv_active_in,
    input wire [1:0]   addr_sel_in,
    input wire [7:0]   ptr_in,
    input wire [15:0]  ideality_in,
    input wire [143:0] limit1_in,
    input wire [15:0]  rd_word_out,
    input wire         rd_valid_out,
    input wire [7:0]   remote_open_fault_bit_out,
    input wire [6:0]   target_addr_out,
    input wire         ideality_default_out,
    input wire         conv_timeout_out,
    input wire         primary_overtemp_alert_n_out
);
    // ****
    // Properties
    // ****
    wire pv = ptr_in <= 8'h08 || (ptr_in >= 8'h80 && ptr_in <= 8'h88);
    wire [7:0] fb = remote_open_fault_bit_out;
    // Cycles of a conversion running without a done pulse
    logic [31:0] act_run;
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            act_run <= 32'h0000_0000;
        else if (conv_active_in && !conv_done_in)
            act_run <= act_run + 32'h0000_0001;
        else
            act_run <= 32'h0000_0000;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence fault_seen;
        (fault_cmp_in && conv_active_in && conv_ch_in != 4'h0 && conv_ch_in <= 4'h8 && $stable(conv_ch_in))[*4];
    endsequence
    sequence hot_local;
        conv_done_in && conv_ch_in == 4'h0 && $signed({conv_raw_in, 3'h0}) > $signed(limit1_in[15:0]);
    endsequence
    bad_ptr_a: assert property (!pv |=> !rd_valid_out && rd_word_out == 16'h0000) else $error("bad ptr");
    good_ptr_a: assert property (pv |=> rd_valid_out) else $error("ptr refused");
    low_bits_a: assert property (rd_valid_out |-> rd_word_out[2:0] == 3'h0) else $error("low bits");
    addr_map_a: assert property ($stable(addr_sel_in)[*4] |-> target_addr_out == {5'h12, addr_sel_in})
        else $error("address");
    ideality_flag_a: assert property (1'b1 |=> ideality_default_out == ($past(ideality_in) == 16'h0000))
        else $error("ideality");
    fault_sticky_a: assert property (1'b1 |=> (fb & $past(fb)) == $past(fb)) else $error("fault lost");
    fault_set_a: assert property (fault_seen |-> ##2 fb[$past(conv_ch_in, 2) - 4'h1]) else $error("no fault");
    alert_on_a: assert property (hot_local |-> ##[3:4] !primary_overtemp_alert_n_out) else $error("alert");
    timeout_set_a: assert property (act_run > CONV_LIMIT |-> conv_timeout_out) else $error("no timeout");
    timeout_early_a: assert property (act_run <= CONV_LIMIT && !$past(conv_done_in) |-> !conv_timeout_out)
        else $error("early timeout");
endmodule
bind mctr_top mctr_properties #(.CONV_LIMIT(CONV_LIMIT)) i_props (.mclk_in, .rst_n_in, .conv_done_in,
    .conv_ch_in, .conv_raw_in, .fault_cmp_in, .conv_active_in, .addr_sel_in, .ptr_in, .ideality_in,
    .limit1_in, .rd_word_out, .rd_valid_out, .remote_open_fault_bit_out, .target_addr_out,
    .ideality_default_out, .conv_timeout_out, .primary_overtemp_alert_n_out);
`default_nettype wire

/* mctr_host_model.sv */
// Host stand-in that selects a result and takes the word
`timescale 1ns/10ps
`default_nettype none
module mctr_host_model
(
    input  wire        mclk_in,
    input  wire [15:0] rd_word_in,
    input  wire        rd_valid_in,
    output logic [7:0] ptr_out
);
    // ****
    // Pointer write and word read
    // ****
    initial ptr_out = 8'h00;
    task automatic read_word(input logic [7:0] p, output logic [15:0] w, output logic v);
    begin
        @(negedge mclk_in);
        ptr_out = p;
        repeat (2) @(negedge mclk_in);
        w = rd_word_in;
        v = rd_valid_in;
    end
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the result logic top
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ****
    // Stimulus and checks
    // ****
    logic mclk_in = 0, rst_n_in = 0, conv_done_in = 0, short_in = 0, fault_cmp_in = 0, conv_active_in = 0, v;
    logic rd_valid_out, ideality_default_out, conv_timeout_out, primary_overtemp_alert_n_out;
    logic secondary_overtemp_alert_n_out;
    logic [3:0]   conv_ch_in = 4'h0;
    logic [12:0]  conv_raw_in = 13'h0000;
    logic [1:0]   addr_sel_in = 2'h0;
    logic [7:0]   ptr_in, remote_open_fault_bit_out;
    logic [6:0]   target_addr_out;
    logic [15:0]  ideality_in = 16'h0000, hyst_in = 16'h0500, rd_word_out, w;
    logic [143:0] limit1_in = {{8{16'h7ff8}}, 16'h3200}, limit2_in = {{8{16'h7ff8}}, 16'h4b00};
    logic [15:0]  tbl [9] = '{16'h0008, 16'hfff8, 16'h7ff8, 16'h8000, 16'h0c80, 16'he700, 16'h3e80, 16'hf380, 16'h4b00};
    logic [15:0]  alw [4] = '{16'h3280, 16'h4b80, 16'h3000, 16'h2c00};
    logic [1:0]   ale [4] = '{2'h1, 2'h0, 2'h1, 2'h3};
    int fail_count = 0, num_checks = 0, cyc = 0;
    mctr_top #(.CONV_LIMIT(100)) i_mctr_top
    (
        .mclk_in                        (mclk_in),
        .rst_n_in                       (rst_n_in),
        .conv_done_in                   (conv_done_in),
        .conv_ch_in                     (conv_ch_in),
        .conv_raw_in                    (conv_raw_in),
        .short_in                       (short_in),
        .fault_cmp_in                   (fault_cmp_in),
        .conv_active_in                 (conv_active_in),
        .addr_sel_in                    (addr_sel_in),
        .ptr_in                         (ptr_in),
        .ideality_in                    (ideality_in),
        .hyst_in                        (hyst_in),
        .limit1_in                      (limit1_in),
        .limit2_in                      (limit2_in),
        .rd_word_out                    (rd_word_out),
        .rd_valid_out                   (rd_valid_out),
        .remote_open_fault_bit_out      (remote_open_fault_bit_out),
        .target_addr_out                (target_addr_out),
        .ideality_default_out           (ideality_default_out),
        .conv_timeout_out               (conv_timeout_out),
        .primary_overtemp_alert_n_out   (primary_overtemp_alert_n_out),
        .secondary_overtemp_alert_n_out (secondary_overtemp_alert_n_out)
    );
    mctr_host_model i_host (.mclk_in, .rd_word_in(rd_word_out), .rd_valid_in(rd_valid_out), .ptr_out(ptr_in));
    always #2 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
    begin
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    end
    endtask
    task automatic conv(input logic [3:0] c, input logic [15:0] x);
    begin
        @(negedge mclk_in);
        conv_done_in = 1;
        conv_ch_in = c;
        conv_raw_in = x[15:3];
        @(negedge mclk_in);
        conv_done_in = 0;
    end
    endtask
    task automatic rd(input logic [7:0] p, input logic [15:0] e, input logic ev);
    begin
        i_host.read_word(p, w, v);
        chk(e, w);
        chk({15'h0, ev}, {15'h0, v});
    end
    endtask
    task automatic finish_test;
    begin
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (20) @(negedge mclk_in);
        rst_n_in = 1;
        chk(16'h0048, {9'h0, target_addr_out});
        chk(16'h0003, {14'h0, primary_overtemp_alert_n_out, secondary_overtemp_alert_n_out});
        for (int c = 0; c < 9; c++)
            conv(c[3:0], tbl[c]);
        for (int c = 0; c < 9; c++)
        begin
            rd(c[7:0], tbl[c], 1'b1);
            rd(8'h80 + c[7:0], tbl[c], 1'b1);
        end
        rd(8'h09, 16'h0000, 1'b0);
        rd(8'h89, 16'h0000, 1'b0);
        short_in = 1;
        repeat (3) @(negedge mclk_in);
        conv(4'h2, 16'h0c80);
        conv(4'h0, 16'h0c80);
        rd(8'h02, 16'h8000, 1'b1);
        rd(8'h00, 16'h0c80, 1'b1);
        short_in = 0;
        fault_cmp_in = 1;
        conv_active_in = 1;
        conv_ch_in = 4'h5;
        repeat (6) @(negedge mclk_in);
        fault_cmp_in = 0;
        repeat (90) @(negedge mclk_in);
        chk(16'h0010, {8'h0, remote_open_fault_bit_out});
        chk(16'h0000, {15'h0, conv_timeout_out});
        repeat (20) @(negedge mclk_in);
        chk(16'h0001, {15'h0, conv_timeout_out});
        conv_active_in = 0;
        repeat (3) @(negedge mclk_in);
        chk(16'h0000, {15'h0, conv_timeout_out});
        chk(16'h0001, {15'h0, ideality_default_out});
        ideality_in = 16'h0001;
        repeat (2) @(negedge mclk_in);
        chk(16'h0000, {15'h0, ideality_default_out});
        for (int a = 0; a < 4; a++)
        begin
            addr_sel_in = a[1:0];
            repeat (5) @(negedge mclk_in);
            chk(16'h0048 | a[15:0], {9'h0, target_addr_out});
        end
        conv(4'h1, 16'h1900);
        conv(4'h1, 16'h1980);
        rd(8'h81, 16'h1980, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            conv(4'h0, alw[k]);
            repeat (4) @(negedge mclk_in);
            chk({14'h0, ale[k]}, {14'h0, primary_overtemp_alert_n_out, secondary_overtemp_alert_n_out});
        end
        finish_test();
    end
endmodule
`default_nettype wire
